//--- radio_spi_command_decoder.sv
// Purpose: spi slave command decoder for a packet radio
// Assumes: spi mode 0; sck, csn_n, mosi asynchronous to core_clk, sck well below core_clk/8
// Notes: payload bytes leave through a small buffer; a word refused when full flags overrun
`timescale 1ns/1ps
module radio_spi_command_decoder #(
   parameter int unsigned BUF_DEPTH = 2,
   parameter int unsigned BUF_WIDTH = 14
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       sck,
   input  wire logic       csn_n,
   input  wire logic       mosi,
   output logic            miso,
   output logic            miso_oe,
   input  wire logic [7:0] status_in,
   input  wire logic [2:0] rx_pipe_in,
   input  wire logic [2:0] irq_src,
   input  wire logic [2:0] irq_mask,
   output logic            irq_n,
   input  wire logic       standby_or_pd,
   input  wire logic       feat_dyn_width_en,
   input  wire logic       feat_ack_pay_en,
   input  wire logic       feat_noack_en,
   input  wire logic [1:0] ack_pending,
   output logic [4:0]      reg_addr,
   output logic [2:0]      reg_rd_idx,
   input  wire logic [7:0] reg_rd_data,
   output logic            reg_wr_valid,
   output logic [2:0]      reg_wr_idx,
   output logic [7:0]      reg_wr_data,
   output logic [4:0]      rx_idx,
   input  wire logic [7:0] rx_rd_data,
   input  wire logic [5:0] rx_head_width,
   output logic            rx_pop,
   output logic            flush_tx,
   output logic            flush_rx,
   output logic            reuse_active,
   output logic            pl_valid,
   input  wire logic       pl_ready,
   output logic [7:0]      pl_data,
   output logic [1:0]      pl_kind,
   output logic [2:0]      pl_pipe,
   output logic            pl_end,
   output logic            spi_overrun
);

   localparam int unsigned PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

   if (BUF_DEPTH < 2 || BUF_WIDTH != spi_cmd_pkg::ENTRY_WIDTH) begin : g_bad_param
      $error("buffer needs depth of two or more and a fourteen bit entry");
   end

   function automatic spi_cmd_pkg::op_e decode(input logic [7:0] c, input logic wr_ok,
                                               input logic wid_en, input logic ack_en,
                                               input logic noack_en, input logic [1:0] pend);
      spi_cmd_pkg::op_e op;
      op = spi_cmd_pkg::OP_IGNORE;
      if (c[7:5] == spi_cmd_pkg::CMD_REG_RD_TOP) begin
         op = spi_cmd_pkg::OP_REG_RD;
      end else if (c[7:5] == spi_cmd_pkg::CMD_REG_WR_TOP && wr_ok) begin
         op = spi_cmd_pkg::OP_REG_WR;
      end else if (c == spi_cmd_pkg::CMD_RX_RD) begin
         op = spi_cmd_pkg::OP_RX_RD;
      end else if (c == spi_cmd_pkg::CMD_RX_WID && wid_en) begin
         op = spi_cmd_pkg::OP_RX_WID;
      end else if (c == spi_cmd_pkg::CMD_TX_WR) begin
         op = spi_cmd_pkg::OP_TX_WR;
      end else if (c[7:3] == spi_cmd_pkg::CMD_ACK_WR_TOP && ack_en &&
                   c[2:0] <= spi_cmd_pkg::ACK_PIPE_MAX &&
                   pend < spi_cmd_pkg::ACK_PENDING_MAX) begin
         op = spi_cmd_pkg::OP_ACK_WR;
      end else if (c == spi_cmd_pkg::CMD_NOACK_WR && noack_en) begin
         op = spi_cmd_pkg::OP_NOACK_WR;
      end else if (c == spi_cmd_pkg::CMD_FLUSH_TX) begin
         op = spi_cmd_pkg::OP_FLUSH_TX;
      end else if (c == spi_cmd_pkg::CMD_FLUSH_RX) begin
         op = spi_cmd_pkg::OP_FLUSH_RX;
      end else if (c == spi_cmd_pkg::CMD_REUSE) begin
         op = spi_cmd_pkg::OP_REUSE;
      end else if (c == spi_cmd_pkg::CMD_NOP) begin
         op = spi_cmd_pkg::OP_NOP;
      end
      return op;
   endfunction

   // pin synchronisers: bit0 first stage, bit1 synced, bit2 previous
   logic [2:0] sck_q, csn_q, mosi_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sck_q  <= spi_cmd_pkg::SCK_SYNC_RESET;
         csn_q  <= spi_cmd_pkg::CSN_SYNC_RESET;
         mosi_q <= 3'h0;
      end else begin
         sck_q  <= {sck_q[1:0], sck};
         csn_q  <= {csn_q[1:0], csn_n};
         mosi_q <= {mosi_q[1:0], mosi};
      end
   end

   spi_cmd_pkg::state_e state_q;
   spi_cmd_pkg::op_e    op_q;
   logic [2:0] bit_cnt_q, pipe_q, reg_wr_idx_q;
   logic [5:0] byte_cnt_q;
   logic [6:0] shift_in_q;
   logic [7:0] shift_out_q, reg_wr_data_q;
   logic [4:0] addr_q;
   logic       oe_q, load_pend_q, end_pend_q, overrun_q, irq_n_q, reuse_q;
   logic       reg_wr_valid_q, rx_pop_q, flush_tx_q, flush_rx_q;

   wire sck_rise  = sck_q[1] & ~sck_q[2];
   wire sck_fall  = ~sck_q[1] & sck_q[2];
   wire csn_fall  = ~csn_q[1] & csn_q[2];
   wire csn_rise  = csn_q[1] & ~csn_q[2];
   wire byte_done = sck_rise & ~csn_q[1] & (state_q != spi_cmd_pkg::ST_IDLE) &
                    (bit_cnt_q == spi_cmd_pkg::BIT_LAST);
   wire [7:0] byte_val = {shift_in_q, mosi_q[1]};
   wire cmd_done  = byte_done & (state_q == spi_cmd_pkg::ST_CMD);
   wire data_done = byte_done & (state_q == spi_cmd_pkg::ST_DATA);
   wire [7:0] status_byte = {status_in[7:4], pipe_q, status_in[0]};
   spi_cmd_pkg::op_e dec_op;
   assign dec_op = decode(byte_val, standby_or_pd, feat_dyn_width_en, feat_ack_pay_en,
                          feat_noack_en, ack_pending);

   // next byte on miso for read commands
   wire [7:0] rd_byte =
      (op_q == spi_cmd_pkg::OP_REG_RD && byte_cnt_q < spi_cmd_pkg::REG_MAX_BYTES) ?
         reg_rd_data :
      (op_q == spi_cmd_pkg::OP_RX_RD && byte_cnt_q < spi_cmd_pkg::PL_MAX_BYTES) ?
         rx_rd_data :
      (op_q == spi_cmd_pkg::OP_RX_WID && byte_cnt_q == 6'h00) ?
         {2'h0, rx_head_width} : 8'h00;

   wire is_pl = (op_q == spi_cmd_pkg::OP_TX_WR) || (op_q == spi_cmd_pkg::OP_ACK_WR) ||
                (op_q == spi_cmd_pkg::OP_NOACK_WR);
   wire [1:0] kind = (op_q == spi_cmd_pkg::OP_ACK_WR)   ? spi_cmd_pkg::PL_KIND_ACK :
                     (op_q == spi_cmd_pkg::OP_NOACK_WR) ? spi_cmd_pkg::PL_KIND_NOACK :
                                                          spi_cmd_pkg::PL_KIND_TX;
   wire push_data = data_done & is_pl & (byte_cnt_q < spi_cmd_pkg::PL_MAX_BYTES);
   wire in_ready;
   wire in_valid = end_pend_q | push_data;
   wire [13:0] in_entry = end_pend_q ? {1'b1, kind, addr_q[2:0], 8'h00} :
                                       {1'b0, kind, addr_q[2:0], byte_val};
   wire end_commit = end_pend_q & in_ready;
   wire lost = push_data & (end_pend_q | ~in_ready);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= spi_cmd_pkg::ST_IDLE;
         op_q <= spi_cmd_pkg::OP_IGNORE;
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 6'h00;
         shift_in_q <= 7'h00;
         shift_out_q <= 8'h00;
         addr_q <= 5'h00;
         oe_q <= 1'b0;
         load_pend_q <= 1'b0;
      end else if (csn_fall) begin
         state_q <= spi_cmd_pkg::ST_CMD;
         op_q <= spi_cmd_pkg::OP_IGNORE;
         bit_cnt_q <= 3'h0;
         byte_cnt_q <= 6'h00;
         shift_out_q <= status_byte;
         oe_q <= 1'b1;
         load_pend_q <= 1'b0;
      end else if (csn_rise) begin
         state_q <= spi_cmd_pkg::ST_IDLE;
         oe_q <= 1'b0;
      end else begin
         if (sck_rise && state_q != spi_cmd_pkg::ST_IDLE) begin
            shift_in_q <= byte_val[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
         end
         if (cmd_done) begin
            state_q <= spi_cmd_pkg::ST_DATA;
            op_q <= dec_op;
            addr_q <= byte_val[4:0];
         end
         if (data_done && byte_cnt_q != spi_cmd_pkg::BYTE_CNT_MAX) begin
            byte_cnt_q <= byte_cnt_q + 6'h01;
         end
         if (byte_done) begin
            load_pend_q <= 1'b1;
         end else if (sck_fall) begin
            load_pend_q <= 1'b0;
         end
         if (sck_fall && state_q != spi_cmd_pkg::ST_IDLE) begin
            shift_out_q <= load_pend_q ? rd_byte : {shift_out_q[6:0], 1'b0};
         end
      end
   end

   // side effects of commands
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_wr_valid_q <= 1'b0;
         reg_wr_idx_q <= 3'h0;
         reg_wr_data_q <= 8'h00;
         rx_pop_q <= 1'b0;
         flush_tx_q <= 1'b0;
         flush_rx_q <= 1'b0;
         reuse_q <= 1'b0;
         end_pend_q <= 1'b0;
         overrun_q <= 1'b0;
         pipe_q <= spi_cmd_pkg::PIPE_RESET;
         irq_n_q <= 1'b1;
      end else begin
         reg_wr_valid_q <= data_done && op_q == spi_cmd_pkg::OP_REG_WR &&
                           byte_cnt_q < spi_cmd_pkg::REG_MAX_BYTES;
         if (data_done) begin
            reg_wr_idx_q <= byte_cnt_q[2:0];
            reg_wr_data_q <= byte_val;
         end
         rx_pop_q <= csn_rise && op_q == spi_cmd_pkg::OP_RX_RD &&
                     byte_cnt_q != 6'h00;
         flush_tx_q <= cmd_done && dec_op == spi_cmd_pkg::OP_FLUSH_TX;
         flush_rx_q <= cmd_done && dec_op == spi_cmd_pkg::OP_FLUSH_RX;
         if (cmd_done && dec_op == spi_cmd_pkg::OP_REUSE) begin
            reuse_q <= 1'b1;
         end else if ((cmd_done && dec_op == spi_cmd_pkg::OP_FLUSH_TX) ||
                      (end_commit && op_q == spi_cmd_pkg::OP_TX_WR)) begin
            reuse_q <= 1'b0;
         end
         if (csn_rise && is_pl && byte_cnt_q != 6'h00) begin
            end_pend_q <= 1'b1;
         end else if (in_ready) begin
            end_pend_q <= 1'b0;
         end
         if (lost) begin
            overrun_q <= 1'b1;
         end else if (csn_fall) begin
            overrun_q <= 1'b0;
         end
         irq_n_q <= ~|(irq_src & ~irq_mask);
         if (irq_n_q && |(irq_src & ~irq_mask)) begin
            pipe_q <= rx_pipe_in;
         end
      end
   end

   // two-entry payload buffer, order kept per pipe
   logic [BUF_WIDTH-1:0] mem_q [BUF_DEPTH];
   logic [PW-1:0] wr_ptr_q, rd_ptr_q;
   logic [PW:0]   count_q;
   wire do_push = in_valid & in_ready;
   wire do_pop  = pl_valid & pl_ready;
   assign in_ready = (count_q < (PW+1)'(BUF_DEPTH));
   assign pl_valid = (count_q != '0);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (do_push) begin
            mem_q[wr_ptr_q] <= in_entry;
            wr_ptr_q <= (wr_ptr_q == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_q <= (rd_ptr_q == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
      end
   end
   wire [BUF_WIDTH-1:0] head = mem_q[rd_ptr_q];

   assign miso = shift_out_q[7];
   assign miso_oe = oe_q;
   assign irq_n = irq_n_q;
   assign reg_addr = addr_q;
   assign reg_rd_idx = byte_cnt_q[2:0];
   assign reg_wr_valid = reg_wr_valid_q;
   assign reg_wr_idx = reg_wr_idx_q;
   assign reg_wr_data = reg_wr_data_q;
   assign rx_idx = byte_cnt_q[4:0];
   assign rx_pop = rx_pop_q;
   assign flush_tx = flush_tx_q;
   assign flush_rx = flush_rx_q;
   assign reuse_active = reuse_q;
   assign pl_data = head[7:0];
   assign pl_pipe = head[10:8];
   assign pl_kind = head[12:11];
   assign pl_end = head[13];
   assign spi_overrun = overrun_q;

   a_status_load: assert property (@(posedge core_clk) disable iff (rst)
      csn_fall |=> (shift_out_q == $past(status_byte)) && miso_oe)
      else $error("status byte not loaded at frame start");
   a_frame_restart: assert property (@(posedge core_clk) disable iff (rst)
      csn_fall |=> state_q == spi_cmd_pkg::ST_CMD && bit_cnt_q == 3'h0 && byte_cnt_q == 6'h00)
      else $error("frame did not restart on chip-select fall");
   a_regwr_mode: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr_valid |-> $past(op_q == spi_cmd_pkg::OP_REG_WR) && reg_wr_idx < 3'h5)
      else $error("register write outside allowed op or byte range");
   a_flush_clears: assert property (@(posedge core_clk) disable iff (rst)
      flush_tx |-> !reuse_active)
      else $error("reuse stayed active after tx flush");
   a_ack_pipe: assert property (@(posedge core_clk) disable iff (rst)
      do_push && in_entry[12:11] == spi_cmd_pkg::PL_KIND_ACK |-> in_entry[10:8] <= 3'h5)
      else $error("ack payload pushed for an invalid pipe");
   a_pop_cause: assert property (@(posedge core_clk) disable iff (rst)
      rx_pop |-> $past(csn_rise) && op_q == spi_cmd_pkg::OP_RX_RD)
      else $error("rx pop without a finished payload read");
   a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
      ##1 irq_n == !$past(|(irq_src & ~irq_mask)))
      else $error("interrupt output does not follow unmasked sources");
   a_nop_quiet: assert property (@(posedge core_clk) disable iff (rst)
      (op_q == spi_cmd_pkg::OP_NOP || op_q == spi_cmd_pkg::OP_IGNORE) ##1
      (op_q == spi_cmd_pkg::OP_NOP || op_q == spi_cmd_pkg::OP_IGNORE) |->
      !reg_wr_valid && !rx_pop && !do_push)
      else $error("no-operation frame changed state");
   a_buf_bound: assert property (@(posedge core_clk) disable iff (rst)
      count_q == (PW+1)'(BUF_DEPTH) |-> !in_ready)
      else $error("full buffer still accepts");

endmodule

//--- spi_cmd_pkg.sv
// Purpose: constants and types for the radio spi command decoder
// Assumes: spi mode 0, host is the spi master, one command byte per frame
// Notes:
// Operation
// - every command starts at a chip-select falling edge; each such edge restarts decoding
// - status byte shifts out on miso while the command byte shifts in
// - command byte msb first; data bytes lsbyte first, msb first within each
// - register read command returns one to five bytes, least significant byte first
// - register write command accepted only in power-down or standby
// - rx payload read returns up to 32 bytes from byte 0, then pops payload
// - tx payload write loads up to 32 bytes, always from byte 0
// - tx flush command has no data and empties the tx fifo
// - rx flush command has no data and empties the rx fifo
// - payload reuse stays active until a tx payload write or tx flush
// - width read command returns one byte, width of the rx fifo head payload
// - ack payload write for pipes 0 to 5 only, up to 32 bytes from byte 0
// - at most three ack payloads pending; same-pipe payloads kept in order
// - no-ack tx write loads payload sent without automatic_acknowledge
// - no_operation_cmd changes nothing and only returns status
// - width read, ack write and no-ack write need their feature enables set
// - multi-byte registers lsbyte first; early end leaves higher bytes unchanged
// - status pipe field updates on the interrupt falling edge
// - interrupt output is active low, driven by three maskable sources
package spi_cmd_pkg;

   localparam logic [2:0] CMD_REG_RD_TOP   = 3'h0;
   localparam logic [2:0] CMD_REG_WR_TOP   = 3'h1;
   localparam logic [4:0] CMD_ACK_WR_TOP   = 5'h15;
   localparam logic [7:0] CMD_RX_RD        = 8'h61;
   localparam logic [7:0] CMD_RX_WID       = 8'h60;
   localparam logic [7:0] CMD_TX_WR        = 8'ha0;
   localparam logic [7:0] CMD_NOACK_WR     = 8'hb0;
   localparam logic [7:0] CMD_FLUSH_TX     = 8'he1;
   localparam logic [7:0] CMD_FLUSH_RX     = 8'he2;
   localparam logic [7:0] CMD_REUSE        = 8'he3;
   localparam logic [7:0] CMD_NOP          = 8'hff;

   localparam logic [5:0] REG_MAX_BYTES    = 6'h05;
   localparam logic [5:0] PL_MAX_BYTES     = 6'h20;
   localparam logic [5:0] BYTE_CNT_MAX     = 6'h3f;
   localparam logic [2:0] ACK_PIPE_MAX     = 3'h5;
   localparam logic [1:0] ACK_PENDING_MAX  = 2'h3;
   localparam logic [2:0] BIT_LAST         = 3'h7;

   localparam logic [1:0] PL_KIND_TX       = 2'h0;
   localparam logic [1:0] PL_KIND_ACK      = 2'h1;
   localparam logic [1:0] PL_KIND_NOACK    = 2'h2;

   localparam logic [2:0] PIPE_RESET       = 3'h7;
   localparam logic [2:0] SCK_SYNC_RESET   = 3'h0;
   localparam logic [2:0] CSN_SYNC_RESET   = 3'h7;
   localparam int unsigned ENTRY_WIDTH     = 14;

   typedef enum logic [3:0] {
      OP_IGNORE, OP_REG_RD, OP_REG_WR, OP_RX_RD, OP_RX_WID, OP_TX_WR, OP_ACK_WR,
      OP_NOACK_WR, OP_FLUSH_TX, OP_FLUSH_RX, OP_REUSE, OP_NOP
   } op_e;

   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA} state_e;

endpackage

//--- spi_host_model.sv
// Purpose: host spi master driving frames into the command decoder
// Assumes: spi mode 0, 125 ns sck period, sck idles low outside frames
// Notes: tx_q[0] is the command, rx_q[0] collects the status byte
`timescale 1ns/1ps
module spi_host_model (
   output logic      sck,
   output logic      csn_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   logic [7:0] tx_q [0:39];
   logic [7:0] rx_q [0:39];

   initial begin
      sck = 1'b0;
      csn_n = 1'b1;
      mosi = 1'b0;
   end

   // nbits below a byte multiple aborts the frame mid-byte
   task automatic xfer(input int nbits);
      int i;
      csn_n = 1'b0;
      for (i = 0; i < nbits; i++) begin
         mosi = tx_q[i / 8][7 - (i % 8)];
         #62.5 sck = 1'b1;
         rx_q[i / 8][7 - (i % 8)] = miso_oe ? miso : 1'bx;
         #62.5 sck = 1'b0;
      end
      #62.5 csn_n = 1'b1;
      mosi = ~mosi;
      #250;
   endtask
endmodule

//--- tb_radio_spi_command_decoder.sv
// Purpose: self-checking bench for the radio spi command decoder
// Assumes: status_in fixed at 8'h40, register and rx data answered from the index
// Notes: frames come from spi_host_model; payload entries logged at the buffer output
`timescale 1ns/1ps
module tb_radio_spi_command_decoder;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        sck, csn_n, mosi, miso, miso_oe, irq_n, reg_wr_valid, rx_pop;
   logic        flush_tx, flush_rx, reuse_active, pl_valid, pl_end, spi_overrun;
   logic        standby_or_pd = 1'b0, wid_en = 1'b0, ack_en = 1'b0, noack_en = 1'b0;
   logic        pl_ready = 1'b1;
   logic [1:0]  ack_pending = 2'h0;
   logic [1:0]  pl_kind;
   logic [2:0]  irq_src = 3'h0, irq_mask = 3'h0, rx_pipe_in = 3'h0;
   logic [2:0]  reg_rd_idx, reg_wr_idx, pl_pipe;
   logic [4:0]  reg_addr, rx_idx;
   logic [7:0]  reg_wr_data, pl_data;
   logic [13:0] pl_q [$];
   logic [10:0] wr_q [$];
   int          num_errors = 0, checks = 0, n_pop = 0, n_ftx = 0, n_frx = 0, k;

   always #2 core_clk = ~core_clk;

   spi_host_model i_host (.sck(sck), .csn_n(csn_n), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe));

   radio_spi_command_decoder i_dut (.core_clk(core_clk), .rst(rst), .sck(sck),
      .csn_n(csn_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .status_in(8'h40),
      .rx_pipe_in(rx_pipe_in), .irq_src(irq_src), .irq_mask(irq_mask), .irq_n(irq_n),
      .standby_or_pd(standby_or_pd), .feat_dyn_width_en(wid_en), .feat_ack_pay_en(ack_en),
      .feat_noack_en(noack_en), .ack_pending(ack_pending), .reg_addr(reg_addr),
      .reg_rd_idx(reg_rd_idx), .reg_rd_data({5'h06, reg_rd_idx}),
      .reg_wr_valid(reg_wr_valid), .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data),
      .rx_idx(rx_idx), .rx_rd_data({3'h5, rx_idx}), .rx_head_width(6'h1c),
      .rx_pop(rx_pop), .flush_tx(flush_tx), .flush_rx(flush_rx),
      .reuse_active(reuse_active), .pl_valid(pl_valid), .pl_ready(pl_ready),
      .pl_data(pl_data), .pl_kind(pl_kind), .pl_pipe(pl_pipe), .pl_end(pl_end),
      .spi_overrun(spi_overrun));

   always @(posedge core_clk) begin
      if (reg_wr_valid === 1'b1) wr_q.push_back({reg_wr_idx, reg_wr_data});
      if (pl_valid === 1'b1 && pl_ready === 1'b1) pl_q.push_back({pl_end, pl_kind, pl_pipe, pl_data});
      n_pop += int'(rx_pop === 1'b1);
      n_ftx += int'(flush_tx === 1'b1);
      n_frx += int'(flush_rx === 1'b1);
   end

   task results;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task clr;
      wr_q.delete();
      pl_q.delete();
      n_pop = 0;
      n_ftx = 0;
      n_frx = 0;
   endtask

   // data bytes are 8'hc1, 8'hc2, ... after the command
   task run(input logic [7:0] c, input int nb);
      int j;
      i_host.tx_q[0] = c;
      for (j = 1; j <= nb; j++) i_host.tx_q[j] = 8'hc0 + 8'(j);
      i_host.xfer(8 * (nb + 1));
      @(negedge core_clk);
   endtask

   task chk_none(input string nm);
      chk(nm, 16'h0, 16'(n_pop + n_ftx + n_frx + wr_q.size() + pl_q.size()));
   endtask

   task chk_pl(input logic [1:0] kd, input logic [2:0] p, input int nb);
      int j;
      chk("pl_count", 16'(nb + 1), 16'(pl_q.size()));
      if (pl_q.size() == nb + 1) begin
         for (j = 0; j < nb; j++) begin
            chk("pl_entry", {6'h0, kd, 8'hc1 + 8'(j)}, {5'h0, pl_q[j][13:11], pl_q[j][7:0]});
            if (kd == 2'h1) chk("pl_pipe", {13'h0, p}, {13'h0, pl_q[j][10:8]});
         end
         chk("pl_end", 16'h1, {15'h0, pl_q[nb][13]});
      end
      clr;
   endtask

   task wait_irq(input logic lvl);
      int t;
      for (t = 0; t < 10 && irq_n !== lvl; t++) @(negedge core_clk);
      chk("irq_n", {15'h0, lvl}, {15'h0, irq_n});
      if (irq_n !== lvl) results;
   endtask

   initial begin
      #300000;
      num_errors++;
      $display("BAD watchdog exp done got hang");
      results;
   end

   initial begin
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      run(8'hff, 0);
      chk("status", 16'h004e, {8'h0, i_host.rx_q[0]});
      chk_none("nop_effects");
      standby_or_pd = 1'b1;
      i_host.tx_q[0] = 8'h2a;
      i_host.xfer(4);
      run(8'hff, 0);
      chk("restart", 16'h004e, {8'h0, i_host.rx_q[0]});
      chk_none("abort_effects");
      run(8'h0a, 6);
      for (k = 0; k < 5; k++) chk("reg_rd", 16'h0030 + 16'(k), {8'h0, i_host.rx_q[k + 1]});
      chk("reg_rd_past", 16'h0, {8'h0, i_host.rx_q[6]});
      chk("reg_addr", 16'h000a, {11'h0, reg_addr});
      run(8'h2a, 3);
      chk("wr_count", 16'h3, 16'(wr_q.size()));
      for (k = 0; k < 3 && k < wr_q.size(); k++) chk("wr_byte", 16'(k * 256 + 16'hc1 + k), {5'h0, wr_q[k]});
      clr;
      standby_or_pd = 1'b0;
      run(8'h2a, 1);
      chk_none("wr_refused");
      run(8'h61, 2);
      chk("rx_rd0", 16'h00a0, {8'h0, i_host.rx_q[1]});
      chk("rx_rd1", 16'h00a1, {8'h0, i_host.rx_q[2]});
      chk("rx_pop", 16'h1, 16'(n_pop));
      clr;
      run(8'h60, 1);
      chk("wid_off", 16'h0, {8'h0, i_host.rx_q[1]});
      wid_en = 1'b1;
      run(8'h60, 1);
      chk("wid_on", 16'h001c, {8'h0, i_host.rx_q[1]});
      run(8'he3, 0);
      chk("reuse_on", 16'h1, {15'h0, reuse_active});
      run(8'he2, 0);
      chk("flush_rx", 16'h1, 16'(n_frx));
      chk("reuse_kept", 16'h1, {15'h0, reuse_active});
      run(8'he1, 0);
      chk("flush_tx", 16'h1, 16'(n_ftx));
      chk("reuse_off", 16'h0, {15'h0, reuse_active});
      clr;
      run(8'he3, 0);
      run(8'ha0, 3);
      chk_pl(2'h0, 3'h0, 3);
      chk("reuse_tx_end", 16'h0, {15'h0, reuse_active});
      run(8'hb0, 2);
      chk_none("noack_off");
      noack_en = 1'b1;
      run(8'hb0, 2);
      chk_pl(2'h2, 3'h0, 2);
      ack_en = 1'b1;
      run(8'had, 2);
      chk_pl(2'h1, 3'h5, 2);
      run(8'hae, 1);
      chk_none("ack_pipe6");
      ack_pending = 2'h3;
      run(8'had, 1);
      chk_none("ack_full");
      run(8'hf0, 2);
      chk("unk_status", 16'h004e, {8'h0, i_host.rx_q[0]});
      chk_none("unk_effects");
      pl_ready = 1'b0;
      run(8'ha0, 3);
      chk("buf_full", 16'h3, {14'h0, pl_valid, spi_overrun});
      pl_ready = 1'b1;
      repeat (8) @(negedge core_clk);
      chk("drain0", 16'h00c1, {8'h0, pl_q[0][7:0]});
      chk("drain1", 16'h00c2, {8'h0, pl_q[1][7:0]});
      chk("drained", 16'h0, {15'h0, pl_valid});
      run(8'hff, 0);
      chk("ovr_clear", 16'h0, {15'h0, spi_overrun});
      rx_pipe_in = 3'h3;
      irq_src = 3'h1;
      wait_irq(1'b0);
      rx_pipe_in = 3'h6;
      run(8'hff, 0);
      chk("pipe_field", 16'h0046, {8'h0, i_host.rx_q[0]});
      irq_mask = 3'h1;
      wait_irq(1'b1);
      results;
   end
endmodule
